// >>> hdl/tpdm_defs.svh
// Register offsets, field positions and reset values of the port data mux select block
`ifndef TPDM_DEFS_SVH
`define TPDM_DEFS_SVH

// ==============================================================
// Register byte addresses
`define TPDM_ROUTE_OFS      4'h0
`define TPDM_XBAR_OFS       4'h4
`define TPDM_STATUS_OFS     4'h8

// ==============================================================
// Route register fields
`define TPDM_RT_TOP_LSB     0
`define TPDM_RT_BOT_LSB     4
`define TPDM_RT_SB_LSB      8
`define TPDM_RT_FLIP_BIT    16
`define TPDM_RT_SBANA_BIT   17
`define TPDM_RT_BUFOE_LSB   20
`define TPDM_ROUTE_RST      32'h0000_0000
`define TPDM_ROUTE_MASK     32'h0073_0fff

// ==============================================================
// Crossbar register fields
`define TPDM_XB_SEL_LSB     0
`define TPDM_XB_EN_LSB      8
`define TPDM_XB_LOOP_BIT    12
`define TPDM_XBAR_RST       32'h0000_1000
`define TPDM_XBAR_MASK      32'h0000_173f

// ==============================================================
// Status register fields
`define TPDM_ST_REJ_LSB     20

// ==============================================================
// Bus answers
`define TPDM_RESP_OKAY      2'h0
`define TPDM_RESP_SLVERR    2'h2

`endif

// >>> hdl/tpdm_pkg.sv
// Types shared by the port data mux select block
package tpdm_pkg;

	// ==============================================================
	// Source that a logical port position may carry
	typedef enum logic [3:0] {
		TPDM_SRC_NONE   = 4'h0,
		TPDM_SRC_ROOT   = 4'h1,
		TPDM_SRC_LSEP   = 4'h2,
		TPDM_SRC_SWD    = 4'h3,
		TPDM_SRC_DBGAB  = 4'h4,
		TPDM_SRC_DBGCD  = 4'h5,
		TPDM_SRC_AUX    = 4'h6,
		TPDM_SRC_SBUART = 4'h7,
		TPDM_SRC_LANE   = 4'h8
	} tpdm_src_t;

	// Positive and negative half of a pair
	typedef struct packed {
		logic pos;
		logic neg;
	} tpdm_pair_t;

	// Receptacle data pins, in/out/enable each
	typedef struct packed {
		logic sbTwo;
		logic sbOne;
		logic botDminus;
		logic botDplus;
		logic topDminus;
		logic topDplus;
	} tpdm_pins_t;

endpackage

// >>> hdl/tpdm_mux.sv
// Type-C port data multiplexer select logic with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none
`include "tpdm_defs.svh"

// Notes on behaviour
// - A flipped plug swaps which physical D+/D- pair serves top and bottom.
// - Each output depends on orientation and the selected interface source.
// - Sideband pins swap their two signals when orientation is reversed.
// - Each source has fixed plus/minus pin assignments; only selection varies.
// - UART and sideband UART paths are buffered with separate output enables.
// - Sideband UART may instead pass like an analog switch.
// - Core-routed signals are sampled and driven on the system clock.
// - Crossbar maps main UART, sideband UART, general pins to any core lane.
// - Root port goes to top or bottom pair, never sideband.
// - Low-speed endpoint goes to top or bottom pair, never sideband.
// - Debug clock on plus/sideband one, debug data on minus/sideband two.
// - Debug lines a,c on plus/sideband one; b,d on minus/sideband two.
// - Auxiliary channel plus on plus/sideband one, minus on minus/two.
// - Sideband UART only on sideband pins: out on one, in on two.
// - Lane zero on top pair, lane two on sideband pins.
// - High-speed transmit and receive pairs never pass this block.
// - After reset main UART receive loops buffered onto main UART transmit.
module tpdm_mux
	import tpdm_pkg::*;
#(
	parameter int LANES = 3
)(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// AXI4-Lite slave
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// System-side pair sources, index by source code 1..7
	input  wire tpdm_pair_t [7:0]  sysDrv,
	input  wire tpdm_pair_t [7:0]  sysDrvEn,
	output tpdm_pair_t [7:0]       sysRcv,
	// Main UART and general pins
	input  wire logic              mainUartRx,
	output logic                   mainUartTx,
	input  wire logic [1:0]        generalPinIn,
	output logic [1:0]             generalPinOut,
	output logic [1:0]             generalPinOe,
	// Receptacle data pins
	input  wire tpdm_pins_t        portIn,
	output tpdm_pins_t             portOut,
	output tpdm_pins_t             portOe
);

	if (LANES != 3) begin : g_chk
		$error("tpdm_mux serves exactly three core lanes");
	end

	// ==============================================================
	// Source permission per logical position (0 top, 1 bottom, 2 sideband)
	function automatic logic srcAllowed(input logic [1:0] posIdx, input logic [3:0] src);
		logic ok;
		ok = 1'b0;
		if (src == TPDM_SRC_NONE)
			ok = 1'b1;
		else if (src == TPDM_SRC_ROOT || src == TPDM_SRC_LSEP)
			ok = (posIdx != 2'd2);
		else if (src == TPDM_SRC_SBUART)
			ok = (posIdx == 2'd2);
		else if (src <= TPDM_SRC_LANE)
			ok = 1'b1;
		return ok;
	endfunction

	// ==============================================================
	// Register file
	logic [31:0] routeReg_r, routeReg_nxt;
	logic [31:0] xbarReg_r, xbarReg_nxt;
	logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
	logic [3:0]  awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic [3:0]  wStrb_r, wStrb_nxt;
	logic        bValid_r, bValid_nxt, rValid_r, rValid_nxt;
	logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;
	logic [31:0] rData_r, rData_nxt;
	logic [31:0] statusWord;
	logic [31:0] strbMask;

	// Effective selection after rejection
	logic [3:0] effSrc [3];
	logic [2:0] rejected;
	logic       flip, sbAnalog, loopBack;
	logic [2:0] bufOe, laneEn;

	assign flip     = routeReg_r[`TPDM_RT_FLIP_BIT];
	assign sbAnalog = routeReg_r[`TPDM_RT_SBANA_BIT];
	assign bufOe    = routeReg_r[`TPDM_RT_BUFOE_LSB +: 3];
	assign laneEn   = xbarReg_r[`TPDM_XB_EN_LSB +: 3];
	assign loopBack = xbarReg_r[`TPDM_XB_LOOP_BIT];

	// Illegal choices, and duplicated ones other than the lane code, leave the later position open
	always_comb
	begin
		logic [3:0] reqSrc [3];
		reqSrc[0] = routeReg_r[`TPDM_RT_TOP_LSB +: 4];
		reqSrc[1] = routeReg_r[`TPDM_RT_BOT_LSB +: 4];
		reqSrc[2] = routeReg_r[`TPDM_RT_SB_LSB +: 4];
		for (int i = 0; i < 3; i++)
		begin
			effSrc[i]   = srcAllowed(2'(i), reqSrc[i]) ? reqSrc[i] : TPDM_SRC_NONE;
			for (int j = 0; j < i; j++)
				if (effSrc[j] != TPDM_SRC_NONE && effSrc[j] == effSrc[i] && effSrc[i] != TPDM_SRC_LANE)
					effSrc[i] = TPDM_SRC_NONE;
			rejected[i] = (effSrc[i] != reqSrc[i]);
		end
	end

	assign statusWord = {9'h0, rejected, 3'h0, sbAnalog, 3'h0, flip, effSrc[2], effSrc[1], effSrc[0]};
	assign strbMask   = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

	// AXI4-Lite: address and data taken in either order, answer one cycle after both
	always_comb
	begin
		logic [31:0] merged;
		merged        = 32'h0;
		awHeld_nxt    = awHeld_r;
		wHeld_nxt     = wHeld_r;
		awAddr_nxt    = awAddr_r;
		wData_nxt     = wData_r;
		wStrb_nxt     = wStrb_r;
		bValid_nxt    = bValid_r;
		bResp_nxt     = bResp_r;
		rValid_nxt    = rValid_r;
		rResp_nxt     = rResp_r;
		rData_nxt     = rData_r;
		routeReg_nxt  = routeReg_r;
		xbarReg_nxt   = xbarReg_r;
		if (s_axi_awvalid && !awHeld_r)
		begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_r)
		begin
			wHeld_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (bValid_r && s_axi_bready)
			bValid_nxt = 1'b0;
		if (awHeld_r && wHeld_r && !bValid_r)
		begin
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
			bValid_nxt = 1'b1;
			bResp_nxt  = `TPDM_RESP_OKAY;
			if (awAddr_r == `TPDM_ROUTE_OFS)
			begin
				merged       = (routeReg_r & ~strbMask) | (wData_r & strbMask);
				routeReg_nxt = merged & `TPDM_ROUTE_MASK;
			end
			else if (awAddr_r == `TPDM_XBAR_OFS)
			begin
				merged      = (xbarReg_r & ~strbMask) | (wData_r & strbMask);
				xbarReg_nxt = merged & `TPDM_XBAR_MASK;
			end
			else if (awAddr_r != `TPDM_STATUS_OFS)
				bResp_nxt = `TPDM_RESP_SLVERR;
		end
		if (rValid_r && s_axi_rready)
			rValid_nxt = 1'b0;
		if (s_axi_arvalid && !rValid_r)
		begin
			rValid_nxt = 1'b1;
			rResp_nxt  = `TPDM_RESP_OKAY;
			if (s_axi_araddr == `TPDM_ROUTE_OFS)
				rData_nxt = routeReg_r;
			else if (s_axi_araddr == `TPDM_XBAR_OFS)
				rData_nxt = xbarReg_r;
			else if (s_axi_araddr == `TPDM_STATUS_OFS)
				rData_nxt = statusWord;
			else
			begin
				rData_nxt = 32'h0;
				rResp_nxt = `TPDM_RESP_SLVERR;
			end
		end
	end

	// Registers of the bus slave
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			routeReg_r <= `TPDM_ROUTE_RST;
			xbarReg_r  <= `TPDM_XBAR_RST;
			awHeld_r   <= 1'b0;
			wHeld_r    <= 1'b0;
			awAddr_r   <= 4'h0;
			wData_r    <= 32'h0;
			wStrb_r    <= 4'h0;
			bValid_r   <= 1'b0;
			bResp_r    <= 2'h0;
			rValid_r   <= 1'b0;
			rResp_r    <= 2'h0;
			rData_r    <= 32'h0;
		end
		else
		begin
			routeReg_r <= routeReg_nxt;
			xbarReg_r  <= xbarReg_nxt;
			awHeld_r   <= awHeld_nxt;
			wHeld_r    <= wHeld_nxt;
			awAddr_r   <= awAddr_nxt;
			wData_r    <= wData_nxt;
			wStrb_r    <= wStrb_nxt;
			bValid_r   <= bValid_nxt;
			bResp_r    <= bResp_nxt;
			rValid_r   <= rValid_nxt;
			rResp_r    <= rResp_nxt;
			rData_r    <= rData_nxt;
		end
	end

	assign s_axi_awready = !awHeld_r;
	assign s_axi_wready  = !wHeld_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;
	assign s_axi_arready = !rValid_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rresp   = rResp_r;
	assign s_axi_rdata   = rData_r;

	// ==============================================================
	// Pin routing; every path is sampled and driven on clk_sys, which caps its rate
	tpdm_pins_t portOut_r, portOut_nxt, portOe_r, portOe_nxt;
	tpdm_pair_t [7:0] sysRcv_r, sysRcv_nxt;
	logic       mainUartTx_r, mainUartTx_nxt;
	logic [1:0] gpOut_r, gpOut_nxt, gpOe_r, gpOe_nxt;

	always_comb
	begin
		tpdm_pair_t physIn [3];
		tpdm_pair_t drvVal [3];
		tpdm_pair_t drvOe [3];
		logic [2:0] laneTx, laneRx;
		logic [1:0] laneSel [3];
		laneTx  = '0;
		laneRx  = '0;
		laneSel = '{default: 2'd0};
		drvVal  = '{default: '0};
		drvOe   = '{default: '0};
		// Physical pairs seen from each logical position
		physIn[0] = flip ? '{portIn.botDplus, portIn.botDminus} : '{portIn.topDplus, portIn.topDminus};
		physIn[1] = flip ? '{portIn.topDplus, portIn.topDminus} : '{portIn.botDplus, portIn.botDminus};
		physIn[2] = flip ? '{portIn.sbTwo, portIn.sbOne} : '{portIn.sbOne, portIn.sbTwo};
		// Crossbar: each lane picks main UART, sideband UART or a general pin
		for (int k = 0; k < 3; k++)
		begin
			laneSel[k] = xbarReg_r[`TPDM_XB_SEL_LSB + 2*k +: 2];
			laneRx[k]  = physIn[k].neg;
			case (laneSel[k])
				2'd0:    laneTx[k] = mainUartRx;
				2'd1:    laneTx[k] = sysDrv[TPDM_SRC_SBUART].pos;
				2'd2:    laneTx[k] = generalPinIn[0];
				default: laneTx[k] = generalPinIn[1];
			endcase
		end
		sysRcv_nxt     = '0;
		mainUartTx_nxt = loopBack ? mainUartRx : 1'b1;
		gpOut_nxt      = 2'b00;
		gpOe_nxt       = 2'b00;
		for (int k = 2; k >= 0; k--)
			if (laneEn[k] && effSrc[k] == TPDM_SRC_LANE)
			begin
				if (laneSel[k] == 2'd0 && !loopBack)
					mainUartTx_nxt = laneRx[k];
				else if (laneSel[k] == 2'd1)
					sysRcv_nxt[TPDM_SRC_SBUART].neg = laneRx[k];
				else if (laneSel[k][1])
				begin
					gpOut_nxt[laneSel[k][0]] = laneRx[k];
					gpOe_nxt[laneSel[k][0]]  = 1'b1;
				end
			end
		// Fixed plus/minus assignment of each source on the chosen position
		for (int i = 0; i < 3; i++)
		begin
			drvVal[i] = '0;
			drvOe[i]  = '0;
			if (effSrc[i] == TPDM_SRC_LANE)
			begin
				drvVal[i].pos = laneTx[i];
				drvOe[i].pos  = bufOe[i] & laneEn[i];
			end
			else if (effSrc[i] == TPDM_SRC_SBUART)
			begin
				drvVal[i].pos = sysDrv[TPDM_SRC_SBUART].pos;
				drvOe[i].pos  = sbAnalog ? sysDrvEn[TPDM_SRC_SBUART].pos : bufOe[i];
				sysRcv_nxt[TPDM_SRC_SBUART].neg = physIn[i].neg;
			end
			else if (effSrc[i] != TPDM_SRC_NONE)
			begin
				drvVal[i] = sysDrv[effSrc[i][2:0]];
				drvOe[i]  = sysDrvEn[effSrc[i][2:0]];
				sysRcv_nxt[effSrc[i][2:0]] = physIn[i];
			end
		end
		// Back onto physical pins; no high-speed lane exists here by design
		portOut_nxt = '0;
		portOe_nxt  = '0;
		{portOut_nxt.topDplus, portOut_nxt.topDminus} = flip ? drvVal[1] : drvVal[0];
		{portOe_nxt.topDplus, portOe_nxt.topDminus}   = flip ? drvOe[1] : drvOe[0];
		{portOut_nxt.botDplus, portOut_nxt.botDminus} = flip ? drvVal[0] : drvVal[1];
		{portOe_nxt.botDplus, portOe_nxt.botDminus}   = flip ? drvOe[0] : drvOe[1];
		{portOut_nxt.sbOne, portOut_nxt.sbTwo} = flip ? {drvVal[2].neg, drvVal[2].pos} : drvVal[2];
		{portOe_nxt.sbOne, portOe_nxt.sbTwo}   = flip ? {drvOe[2].neg, drvOe[2].pos} : drvOe[2];
	end

	// Pin registers; outputs come straight from here
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			portOut_r    <= '0;
			portOe_r     <= '0;
			sysRcv_r     <= '0;
			mainUartTx_r <= 1'b1;
			gpOut_r      <= 2'b00;
			gpOe_r       <= 2'b00;
		end
		else
		begin
			portOut_r    <= portOut_nxt;
			portOe_r     <= portOe_nxt;
			sysRcv_r     <= sysRcv_nxt;
			mainUartTx_r <= mainUartTx_nxt;
			gpOut_r      <= gpOut_nxt;
			gpOe_r       <= gpOe_nxt;
		end
	end

	assign portOut       = portOut_r;
	assign portOe        = portOe_r;
	assign sysRcv        = sysRcv_r;
	assign mainUartTx    = mainUartTx_r;
	assign generalPinOut = gpOut_r;
	assign generalPinOe  = gpOe_r;

	// ==============================================================
	// Checks
	flip_swap_a: assert property (@(posedge clk_sys) disable iff (rst)
		(flip && effSrc[0] == TPDM_SRC_ROOT && $stable(routeReg_r)) |=> portOut.botDplus == $past(sysDrv[1].pos))
		else $error("flipped root port not on bottom pair");
	sb_no_root_a: assert property (@(posedge clk_sys) disable iff (rst)
		effSrc[2] != TPDM_SRC_ROOT && effSrc[2] != TPDM_SRC_LSEP)
		else $error("usb pair selected on sideband");
	sb_uart_only_a: assert property (@(posedge clk_sys) disable iff (rst)
		effSrc[0] != TPDM_SRC_SBUART && effSrc[1] != TPDM_SRC_SBUART)
		else $error("sideband uart on data pair");
	no_dup_a: assert property (@(posedge clk_sys) disable iff (rst)
		(effSrc[0] != TPDM_SRC_NONE && effSrc[0] != TPDM_SRC_LANE) |-> (effSrc[1] != effSrc[0] && effSrc[2] != effSrc[0]))
		else $error("source on two positions");
	reset_loop_a: assert property (@(posedge clk_sys)
		$fell(rst) |-> loopBack ##1 mainUartTx == $past(mainUartRx))
		else $error("uart loopback missing after reset");
	buf_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!flip && effSrc[0] == TPDM_SRC_LANE && !bufOe[0] && $stable(routeReg_r)) |=> !portOe.topDplus)
		else $error("buffered lane drives while disabled");
	sb_swap_a: assert property (@(posedge clk_sys) disable iff (rst)
		(flip && effSrc[2] == TPDM_SRC_SWD && $stable(routeReg_r)) |=> portOut.sbTwo == $past(sysDrv[3].pos))
		else $error("sideband pair not swapped");
	sb_analog_a: assert property (@(posedge clk_sys) disable iff (rst)
		(sbAnalog && effSrc[2] == TPDM_SRC_SBUART && !flip && $stable(routeReg_r))
			|=> portOe.sbOne == $past(sysDrvEn[7].pos))
		else $error("analog sideband uart enable wrong");

endmodule // tpdm_mux
`default_nettype wire

// >>> tb/tpdm_cable_model.sv
// Far-side model of the receptacle: cable and attached partner device
`timescale 1ns/1ns
`default_nettype none

module tpdm_cable_model
	import tpdm_pkg::*;
(
	// Clock for the floating-line pattern
	input  wire logic       clk_sys,
	// Device side of the pins
	input  wire tpdm_pins_t portOut,
	input  wire tpdm_pins_t portOe,
	// Far-side drive requested by the bench
	input  wire tpdm_pins_t farDrv,
	input  wire tpdm_pins_t farEn,
	// Resolved pin levels
	output var tpdm_pins_t  portIn
);
	// ==============================================================
	// Floating lines
	// An undriven pin has no pull here, so it toggles to stop a stale value passing
	tpdm_pins_t floatPat = 6'h15;

	always @(posedge clk_sys)
		floatPat <= ~floatPat;

	// Device drive wins, then the far side, else the floating pattern
	assign portIn = (portOe & portOut) | (~portOe & farEn & farDrv) | (~portOe & ~farEn & floatPat);
endmodule // tpdm_cable_model

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the port data mux select block
`timescale 1ns/1ns
`default_nettype none
`include "tpdm_defs.svh"

module tb
	import tpdm_pkg::*;
;
	// ==============================================================
	// Signals
	logic             clk_sys = 1'b0;
	logic             rst = 1'b1;
	logic [3:0]       awaddr = 4'h0, araddr = 4'h0;
	logic [31:0]      wdata = 32'h0;
	logic [3:0]       wstrb = 4'hf;
	logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [1:0]       bresp, rresp, rs;
	logic [31:0]      rdata, rd;
	tpdm_pair_t [7:0] sysDrv = '0, sysDrvEn = '0, sysRcv;
	logic             mainUartRx = 1'b0, mainUartTx;
	logic [1:0]       gpIn = 2'h0, gpOut, gpOe;
	tpdm_pins_t       portIn, portOut, portOe, farDrv = '0, farEn = '0, eo, ee, em;
	int               errors = 0, check_count = 0;
	logic [3:0]       src [3];
	logic             fl, sa;
	logic [2:0]       boe;

	always #2 clk_sys = ~clk_sys;

	// ==============================================================
	// Design and far side
	tpdm_mux #(.LANES(3)) u_tpdm_mux (
		.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sysDrv(sysDrv), .sysDrvEn(sysDrvEn), .sysRcv(sysRcv),
		.mainUartRx(mainUartRx), .mainUartTx(mainUartTx),
		.generalPinIn(gpIn), .generalPinOut(gpOut), .generalPinOe(gpOe),
		.portIn(portIn), .portOut(portOut), .portOe(portOe)
	);

	tpdm_cable_model u_tpdm_cable_model (
		.clk_sys(clk_sys), .portOut(portOut), .portOe(portOe),
		.farDrv(farDrv), .farEn(farEn), .portIn(portIn)
	);

	// ==============================================================
	// Reporting
	task automatic finish_test();
		$display("Checks %0d, errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic timed_out();
		errors++;
		$display("CHECK FAILED bus answer expected within 64 cycles seen none");
		finish_test();
	endtask

	// ==============================================================
	// Bus master: each item held until taken; trailing edge keeps tasks apart
	task automatic bus_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge clk_sys);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		if (n == 64)
			timed_out();
		r = bresp;
		bready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic bus_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge clk_sys);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (n == 64)
			timed_out();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic expect_reg(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		bus_read(a, rd, rs);
		check("read data", d, rd);
		check("read resp", 32'(r), 32'(rs));
	endtask

	// Main UART receive must reappear on transmit one cycle later
	task automatic loop_check();
		logic b;
		repeat (8)
		begin
			b = 1'($urandom);
			mainUartRx <= b;
			@(posedge clk_sys);
			#1;
			check("loopback tx", 32'(b), 32'(mainUartTx));
		end
	endtask

	// ==============================================================
	// Expected pins: enables known except on lane positions and the sideband UART input, values only where driven
	task automatic predict();
		int pp, pm;
		logic ok;
		logic [15:0] used;
		eo = '0;
		ee = '0;
		em = '0;
		used = '0;
		for (int p = 0; p < 3; p++)
		begin
			// Top and bottom trade places when flipped, as do the sideband pins
			pp = (p == 2) ? (fl ? 5 : 4) : (((p == 0) ^ fl) ? 0 : 2);
			pm = (p == 2) ? (fl ? 4 : 5) : pp + 1;
			if (src[p] == 4'h8)
				continue;
			ok = (src[p] inside {[1:6]} && !(p == 2 && src[p] < 3) || src[p] == 4'h7 && p == 2) && !used[src[p]];
			used[src[p]] = used[src[p]] | ok;
			em[pp] = 1'b1;
			em[pm] = !(ok && src[p] == 4'h7);
			if (ok && src[p] == 4'h7)
			begin
				ee[pp] = sa ? sysDrvEn[7].pos : boe[2];
				eo[pp] = sysDrv[7].pos;
			end
			else if (ok)
			begin
				ee[pp] = sysDrvEn[src[p]].pos;
				ee[pm] = sysDrvEn[src[p]].neg;
				eo[pp] = sysDrv[src[p]].pos;
				eo[pm] = sysDrv[src[p]].neg;
			end
		end
	endtask

	// ==============================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'h6f06));
		repeat (5) @(posedge clk_sys);
		check("tx in reset", 32'h1, 32'(mainUartTx));
		check("oe in reset", 32'h0, 32'(portOe));
		rst <= 1'b0;
		loop_check();
		expect_reg(`TPDM_XBAR_OFS, `TPDM_XBAR_RST, `TPDM_RESP_OKAY);
		expect_reg(`TPDM_ROUTE_OFS, `TPDM_ROUTE_RST, `TPDM_RESP_OKAY);
		// Reserved bits, read-only status and an unmapped word
		bus_write(`TPDM_ROUTE_OFS, 32'hffff_ffff, rs);
		expect_reg(`TPDM_ROUTE_OFS, `TPDM_ROUTE_MASK, `TPDM_RESP_OKAY);
		// All three positions hold code 15, so all are refused and flagged
		expect_reg(`TPDM_STATUS_OFS, 32'h0071_1000, `TPDM_RESP_OKAY);
		// Only the low byte lane is written
		wstrb <= 4'h1;
		bus_write(`TPDM_ROUTE_OFS, 32'h0000_0000, rs);
		wstrb <= 4'hf;
		expect_reg(`TPDM_ROUTE_OFS, 32'h0073_0f00, `TPDM_RESP_OKAY);
		bus_write(`TPDM_STATUS_OFS, 32'hffff_ffff, rs);
		check("status write resp", 32'(`TPDM_RESP_OKAY), 32'(rs));
		bus_write(4'hc, 32'h1, rs);
		check("unmapped write resp", 32'(`TPDM_RESP_SLVERR), 32'(rs));
		expect_reg(4'hc, 32'h0, `TPDM_RESP_SLVERR);
		// Every source code at every position first, then random routings
		for (int i = 0; i < 60; i++)
		begin
			for (int p = 0; p < 3; p++)
				src[p] = (i < 10) ? 4'((i + 4 * p + p / 2) % 10) : 4'($urandom_range(0, 9));
			fl = 1'($urandom);
			sa = 1'($urandom);
			boe = 3'($urandom);
			bus_write(`TPDM_ROUTE_OFS, {9'h0, boe, 2'h0, sa, fl, 4'h0, src[2], src[1], src[0]}, rs);
			sysDrv <= 16'($urandom);
			sysDrvEn <= 16'($urandom);
			@(posedge clk_sys);
			#1;
			predict();
			check("pin enables", 32'(ee & em), 32'(portOe & em));
			check("pin values", 32'(eo & ee & em), 32'(portOut & ee & em));
		end
		// Lanes 0 and 2 through the crossbar, loopback off
		bus_write(`TPDM_XBAR_OFS, 32'h0000_0530, rs);
		bus_write(`TPDM_ROUTE_OFS, 32'h0070_0808, rs);
		for (int i = 0; i < 8; i++)
		begin
			farEn <= 6'h22;
			farDrv <= 6'($urandom);
			mainUartRx <= 1'($urandom);
			gpIn <= 2'($urandom);
			@(posedge clk_sys);
			#1;
			check("lane0 rx", 32'(farDrv.topDminus), 32'(mainUartTx));
			check("lane0 tx", 32'(mainUartRx), 32'(portOut.topDplus));
			check("lane0 oe", 32'h1, 32'(portOe.topDplus));
			check("lane2 tx", 32'(gpIn[1]), 32'(portOut.sbOne));
			check("lane2 rx", 32'(farDrv.sbTwo), 32'(gpOut[1]));
			check("gp oe", 32'h2, 32'(gpOe));
		end
		farEn <= '0;
		// Second reset in mid-run brings loopback back
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		loop_check();
		expect_reg(`TPDM_XBAR_OFS, `TPDM_XBAR_RST, `TPDM_RESP_OKAY);
		finish_test();
	end
endmodule // tb

`default_nettype wire
